// *** rtl/asp_baud_timer.sv ***
/*
 * asp_baud_timer: 8-bit up counter with auto-reload and a registered overflow pulse.
 * Assumes i_tick is a one-cycle enable; i_load wins over counting.
 */
`timescale 1ns/100ps
`default_nettype none

module asp_baud_timer (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_tick,
    input  wire logic [7:0] i_reload,
    input  wire logic       i_load,
    input  wire logic [7:0] i_load_val,
    output var  logic [7:0] o_count,
    output var  logic       o_ovf
);
    import asp_pkg::*;

    asp_tmr_state_type q;
    asp_tmr_state_type d;

    always_comb begin
        d     = q;
        d.ovf = 1'b0;
        if (i_load) begin
            d.cnt = i_load_val;
        end else if (i_tick) begin
            if (q.cnt == TMR_TOP) begin
                d.cnt = i_reload;
                d.ovf = 1'b1;
            end else begin
                d.cnt = q.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_count = q.cnt;
    assign o_ovf   = q.ovf;

endmodule : asp_baud_timer
`default_nettype wire

// *** rtl/asp_pkg.sv ***
/*
 * asp_pkg: shared constants and state types for the asynchronous serial port.
 * Assumes an 8-bit register port with a 3-bit word address on the 40 MHz core clock.
 */
package asp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map (word addresses)
    localparam logic [2:0] ADR_CTRL   = 3'h0;  // serial_control_register
    localparam logic [2:0] ADR_DATA   = 3'h1;  // serial_data_buffer
    localparam logic [2:0] ADR_RELOAD = 3'h2;  // baud_reload_byte
    localparam logic [2:0] ADR_TCFG   = 3'h3;  // baud timer configuration
    localparam logic [2:0] ADR_TLOW   = 3'h4;  // baud_timer_low_byte

    // serial_control_register fields
    localparam int BIT_MODE = 7;  // frame_width_select
    localparam int BIT_MCE  = 5;  // multiprocessor_enable
    localparam int BIT_REN  = 4;  // receiver_enable_bit
    localparam int BIT_TB8  = 3;  // transmit_ninth_bit
    localparam int BIT_RB8  = 2;  // received_ninth_bit
    localparam int BIT_TI   = 1;  // transmit_done_flag
    localparam int BIT_RI   = 0;  // receive_done_flag

    // timer configuration fields
    localparam int BIT_RUN    = 0;
    localparam int BIT_SEL_LO = 1;
    localparam int BIT_IRQEN  = 4;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_SEL  = 3'h0;

    // baud timer clock sources
    localparam logic [2:0] SEL_SYS    = 3'h0;
    localparam logic [2:0] SEL_DIV4   = 3'h1;
    localparam logic [2:0] SEL_DIV12  = 3'h2;
    localparam logic [2:0] SEL_DIV48  = 3'h3;
    localparam logic [2:0] SEL_OSC8   = 3'h4;
    localparam logic [2:0] SEL_PIN    = 3'h5;

    // prescaler counts
    localparam logic [5:0] PRE_TOP  = 6'h2F;  // counts 0..47
    localparam logic [2:0] OSC_TOP  = 3'h7;   // external oscillator / 8
    localparam logic [7:0] TMR_TOP  = 8'hFF;

    // frame layout, counted in bit times after the start bit
    localparam logic [3:0] TX_STOP8  = 4'h9;   // stop bit index, 8-bit frame
    localparam logic [3:0] TX_STOP9  = 4'hA;   // stop bit index, 9-bit frame
    localparam logic [3:0] TX_LEN8   = 4'hA;   // ten bits
    localparam logic [3:0] TX_LEN9   = 4'hB;   // eleven bits
    localparam logic [3:0] RX_SH_BITS = 4'h9;  // data plus stop or ninth

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} asp_rx_state_type;

    typedef struct packed {
        logic             mode9;
        logic             mce;
        logic             ren;
        logic             tb8;
        logic             rb8;
        logic             ti;
        logic             ri;
        logic [7:0]       rx_buf;
        logic [7:0]       reload;
        logic             run;
        logic [2:0]       sel;
        logic             irq_en;
        logic [5:0]       pre;
        logic [2:0]       osc_div;
        logic             osc_prev;
        logic             pin_prev;
        logic             tx_phase;
        logic             tx_pend;
        logic [7:0]       tx_byte;
        logic             tx_busy;
        logic [10:0]      tx_sh;
        logic [3:0]       tx_cnt;
        logic             txd;
        asp_rx_state_type rx_state;
        logic             rx_phase;
        logic             rx_prev;
        logic [8:0]       rx_sh;
        logic [3:0]       rx_cnt;
        logic [7:0]       rdata;
        logic             irq;
    } asp_state_type;

    typedef struct packed {
        logic [7:0] cnt;
        logic       ovf;
    } asp_tmr_state_type;

endpackage : asp_pkg

// *** rtl/asp_serial_port.sv ***
/*
 * asp_serial_port: full-duplex asynchronous serial port with baud timer.
 * Assumes a register master on i_core_clk; pins are asynchronous.
 */
// The implementer's own choices: the strobed register port and the register offsets.
// How it works
// - full duplex; 8-bit frame and 9-bit frame selectable
// - received byte held in buffer while next byte arrives
// - write to data buffer loads transmitter and starts sending
// - read of data buffer returns receive buffer only
// - interrupt requested while enabled and either done flag set
// - done flags cleared only by software write
// - baud from 8-bit auto-reload timer; transmit from low byte overflows
// - hidden receive timer runs with baud timer, same reload byte
// - both timer overflow streams divided by two for bit rate
// - start edge forces receive timer reload
// - timer clock: core, /4, /12, /48, oscillator /8, pin
// - external oscillator synchronised and sampled on core clock; every eighth rising edge ticks the timer
// - 8-bit frame: start, 8 data LSB first, stop into ninth field
// - 9-bit frame: start, 8 data, ninth bit, ignored stop
// - load only if receive flag clear and multiprocessor test passes
// - transmit flag set at start of stop bit
`timescale 1ns/100ps
`default_nettype none

module asp_serial_port (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output var  logic [7:0] o_rdata,
    input  wire logic       i_rxd,
    output var  logic       o_txd,
    input  wire logic       i_ext_osc,
    input  wire logic       i_timer_ext_in,
    output var  logic       o_irq
);
    import asp_pkg::*;

    asp_state_type q;
    asp_state_type d;

    logic [2:0] pins_s;
    logic       rx_s;
    logic       osc_s;
    logic       pin_s;
    logic       tmr_tick;
    logic       tx_ovf;
    logic       rx_ovf;
    logic [7:0] tx_count;
    logic       tx_tmr_load;
    logic       rx_force;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and timers

    asp_sync2 #(.W(3)) u_sync (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_async    ({i_timer_ext_in, i_ext_osc, i_rxd}),
        .o_sync     (pins_s)
    );

    assign rx_s  = pins_s[0];
    assign osc_s = pins_s[1];
    assign pin_s = pins_s[2];

    assign tx_tmr_load = i_wr && (i_addr == ADR_TLOW);

    asp_baud_timer u_tx_tmr (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_tick     (tmr_tick),
        .i_reload   (q.reload),
        .i_load     (tx_tmr_load),
        .i_load_val (i_wdata),
        .o_count    (tx_count),
        .o_ovf      (tx_ovf)
    );

    // receive copy: not on the register map, realigned on each start edge
    asp_baud_timer u_rx_tmr (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_tick     (tmr_tick),
        .i_reload   (q.reload),
        .i_load     (rx_force),
        .i_load_val (q.reload),
        .o_count    (),
        .o_ovf      (rx_ovf)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic osc_rise;
        logic pin_rise;
        logic src_tick;
        logic tx_bit;
        logic rx_smp;
        logic set_ti;
        logic set_ri;
        logic rx_done;
        logic [8:0] rx_word;
        logic [3:0] tx_next;

        osc_rise = 1'b0;
        pin_rise = 1'b0;
        src_tick = 1'b0;
        tx_bit   = 1'b0;
        rx_smp   = 1'b0;
        set_ti   = 1'b0;
        set_ri   = 1'b0;
        rx_done  = 1'b0;
        rx_word  = q.rx_sh;
        tx_next  = q.tx_cnt + 4'h1;
        rx_force = 1'b0;

        d       = q;
        d.rdata = RST_BYTE;

        // prescalers; the oscillator path only sees its own edges
        d.pre      = (q.pre == PRE_TOP) ? 6'h00 : q.pre + 6'h01;
        d.osc_prev = osc_s;
        d.pin_prev = pin_s;
        osc_rise   = osc_s && !q.osc_prev;
        pin_rise   = pin_s && !q.pin_prev;
        if (osc_rise) begin
            d.osc_div = q.osc_div + 3'h1;
        end

        unique case (q.sel)
            SEL_SYS:   src_tick = 1'b1;
            SEL_DIV4:  src_tick = (q.pre[1:0] == 2'h3);
            SEL_DIV12: src_tick = (q.pre == 6'h0B) || (q.pre == 6'h17) ||
                                  (q.pre == 6'h23) || (q.pre == PRE_TOP);
            SEL_DIV48: src_tick = (q.pre == PRE_TOP);
            SEL_OSC8:  src_tick = osc_rise && (q.osc_div == OSC_TOP);
            SEL_PIN:   src_tick = pin_rise;
            default:   src_tick = 1'b0;
        endcase
        tmr_tick = q.run && src_tick;

        // halve the overflow streams into bit rates
        if (tx_ovf) begin
            d.tx_phase = !q.tx_phase;
        end
        tx_bit = tx_ovf && q.tx_phase;

        ////////////////////////////////////////////////////////////////////
        // register writes
        if (i_wr) begin
            unique case (i_addr)
                ADR_CTRL: begin
                    d.mode9 = i_wdata[BIT_MODE];
                    d.mce   = i_wdata[BIT_MCE];
                    d.ren   = i_wdata[BIT_REN];
                    d.tb8   = i_wdata[BIT_TB8];
                    d.rb8   = i_wdata[BIT_RB8];
                    d.ti    = i_wdata[BIT_TI];
                    d.ri    = i_wdata[BIT_RI];
                end
                ADR_DATA: begin
                    d.tx_pend = 1'b1;
                    d.tx_byte = i_wdata;
                end
                ADR_RELOAD: d.reload = i_wdata;
                ADR_TCFG: begin
                    d.run    = i_wdata[BIT_RUN];
                    d.sel    = i_wdata[BIT_SEL_LO +: 3];
                    d.irq_en = i_wdata[BIT_IRQEN];
                end
                default: ;
            endcase
        end

        // register reads, answered next cycle
        if (i_rd) begin
            unique case (i_addr)
                ADR_CTRL:   d.rdata = {q.mode9, 1'b0, q.mce, q.ren,
                                       q.tb8, q.rb8, q.ti, q.ri};
                ADR_DATA:   d.rdata = q.rx_buf;
                ADR_RELOAD: d.rdata = q.reload;
                ADR_TCFG:   d.rdata = {3'h0, q.irq_en, q.sel, q.run};
                ADR_TLOW:   d.rdata = tx_count;
                default:    d.rdata = RST_BYTE;
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // transmitter: a frame starts on the first bit time after the write that finds it idle
        if (tx_bit) begin
            if (q.tx_busy) begin
                d.tx_sh  = {1'b1, q.tx_sh[10:1]};  // lsb first
                d.tx_cnt = tx_next;
                if (tx_next == (q.mode9 ? TX_STOP9 : TX_STOP8)) begin
                    set_ti = 1'b1;
                end
                if (tx_next == (q.mode9 ? TX_LEN9 : TX_LEN8)) begin
                    d.tx_busy = 1'b0;
                end
            end else if (q.tx_pend) begin
                // stop, ninth or stop, data, start
                d.tx_sh   = {1'b1, (q.mode9 ? q.tb8 : 1'b1), q.tx_byte, 1'b0};
                d.tx_busy = 1'b1;
                // a data write in this very cycle stays pending
                d.tx_pend = i_wr && (i_addr == ADR_DATA);
                d.tx_cnt  = 4'h0;
            end
        end
        d.txd = d.tx_busy ? d.tx_sh[0] : 1'b1;

        ////////////////////////////////////////////////////////////////////
        // receiver, independent of the transmitter
        d.rx_prev = rx_s;
        if (rx_ovf && (q.rx_state != RX_IDLE)) begin
            d.rx_phase = !q.rx_phase;
        end
        // first overflow after the reload lands mid start bit
        rx_smp = rx_ovf && !q.rx_phase;

        unique case (q.rx_state)
            RX_IDLE: begin
                if (q.ren && q.run && q.rx_prev && !rx_s) begin
                    rx_force   = 1'b1;
                    d.rx_state = RX_START;
                    d.rx_phase = 1'b0;
                    d.rx_cnt   = 4'h0;
                end
            end
            RX_START: begin
                if (rx_smp) begin
                    // a glitch shorter than half a bit is dropped
                    d.rx_state = rx_s ? RX_IDLE : RX_BITS;
                end
            end
            RX_BITS: begin
                if (rx_smp) begin
                    if (q.rx_cnt == RX_SH_BITS) begin
                        rx_done = 1'b1;  // stop of a 9-bit frame ignored
                    end else begin
                        rx_word  = {rx_s, q.rx_sh[8:1]};
                        d.rx_sh  = rx_word;
                        d.rx_cnt = q.rx_cnt + 4'h1;
                        rx_done  = !q.mode9 && ((q.rx_cnt + 4'h1) == RX_SH_BITS);
                    end
                end
            end
            default: d.rx_state = RX_IDLE;
        endcase

        if (rx_done) begin
            d.rx_state = RX_IDLE;
            // overrun leaves the old byte in place
            if (!q.ri && (!q.mce || rx_word[8])) begin
                d.rx_buf = rx_word[7:0];
                d.rb8    = rx_word[8];
                set_ri   = 1'b1;
            end
        end
        if (!q.ren && (q.rx_state != RX_IDLE)) begin
            d.rx_state = RX_IDLE;
        end

        // hardware set beats a same-cycle software clear
        if (set_ti) begin
            d.ti = 1'b1;
        end
        if (set_ri) begin
            d.ri = 1'b1;
        end
        d.irq = d.irq_en && (d.ti || d.ri);
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            q          <= '0;
            q.sel      <= RST_SEL;
            q.txd      <= 1'b1;
            q.osc_prev <= 1'b1;
            q.pin_prev <= 1'b1;
            q.rx_prev  <= 1'b1;
            q.rx_state <= RX_IDLE;
        end else begin
            q <= d;
        end
    end

    assign o_rdata = q.rdata;
    assign o_txd   = q.txd;
    assign o_irq   = q.irq;

endmodule : asp_serial_port
`default_nettype wire

// *** rtl/asp_sync2.sv ***
/*
 * asp_sync2: two-flop synchroniser for a group of unrelated pin levels.
 * Assumes each bit is a slow level; no bus coherence between bits.
 */
`timescale 1ns/100ps
`default_nettype none

module asp_sync2 #(
    parameter int W = 3
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_async,
    output var  logic [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] s2;
        logic [W-1:0] s1;
    } asp_sync_state_type;

    asp_sync_state_type q;
    asp_sync_state_type d;

    always_comb begin
        d    = q;
        d.s1 = i_async;
        d.s2 = q.s1;
    end

    // idle lines are high, so reset to ones avoids a false start edge
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            q <= '1;
        end else begin
            q <= d;
        end
    end

    assign o_sync = q.s2;

endmodule : asp_sync2
`default_nettype wire

// *** sim/asp_remote_uart.sv ***
/*
 * asp_remote_uart: remote transceiver model on the serial lines.
 * Assumes a fixed bit time of BIT core cycles; both lines idle high.
 */
`timescale 1ns/100ps
`default_nettype none

module asp_remote_uart #(
    parameter int BIT = 32
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_line,
    output var  logic       o_line,
    output var  logic [8:0] o_frame,
    output var  int         o_cnt
);
    logic [8:0] sh;

    initial begin
        o_line  = 1'b1;
        o_frame = 9'h000;
        o_cnt   = 0;
    end

    ////////////////////////////////////////////////////////////////////////
    // x is the stop bit of a short frame or the ninth bit of a long one
    task automatic send(input logic [7:0] d, input logic x);
        logic [10:0] f;
        f = {1'b1, x, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge i_core_clk);
            o_line <= f[i];
            repeat (BIT - 1) @(posedge i_core_clk);
        end
        repeat (BIT) @(posedge i_core_clk);
    endtask : send

    task automatic pulse();
        @(posedge i_core_clk);
        o_line <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        o_line <= 1'b1;
        repeat (12 * BIT) @(posedge i_core_clk);
    endtask : pulse

    // mid-bit sampling; ninth sample is the stop or ninth bit
    always begin
        @(negedge i_line);
        repeat (BIT / 2) @(posedge i_core_clk);
        if (!i_line) begin
            for (int i = 0; i < 9; i++) begin
                repeat (BIT) @(posedge i_core_clk);
                sh[i] = i_line;
            end
            o_frame = sh;
            o_cnt++;
        end
    end
endmodule : asp_remote_uart

`default_nettype wire

// *** sim/asp_serial_port_asserts.sv ***
/*
 * asp_serial_port_asserts: port-level checks of the serial port.
 * Assumes it is bound to asp_serial_port and the bus strobes last one cycle.
 */
`timescale 1ns/100ps
`default_nettype none

module asp_serial_port_asserts (
    input wire logic       i_core_clk,
    input wire logic       i_rst_n,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic       i_rxd,
    input wire logic       o_txd,
    input wire logic       i_ext_osc,
    input wire logic       i_timer_ext_in,
    input wire logic       o_irq
);
    import asp_pkg::*;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    ////////////////////////////////////////////////////////////////////////
    sequence s_reload_wr;
        i_wr && i_addr == ADR_RELOAD;
    endsequence
    sequence s_reload_rd;
        i_rd && i_addr == ADR_RELOAD;
    endsequence

    AST_RELOAD_RB: assert property (s_reload_wr ##2 s_reload_rd |=>
        o_rdata == $past(i_wdata, 3)) else $error("reload byte readback wrong");
    AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data outside read answer");
    AST_UNMAPPED: assert property (i_rd && i_addr > ADR_TLOW |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_BIT6_ZERO: assert property (i_rd && i_addr == ADR_CTRL |=> !o_rdata[6])
        else $error("control bit 6 not zero");
    AST_TXD_RESET: assert property ($rose(i_rst_n) |-> o_txd && !o_irq)
        else $error("outputs not idle after reset");
    AST_START_MIN: assert property ($fell(o_txd) |=> !o_txd)
        else $error("start bit shorter than two cycles");
    AST_IRQ_HOLD: assert property (o_irq && !i_wr && !$past(i_wr) |=> o_irq)
        else $error("interrupt dropped without software write");
    AST_IRQ_MASK: assert property (i_wr && i_addr == ADR_TCFG && !i_wdata[BIT_IRQEN]
        |-> ##2 !o_irq) else $error("interrupt high while disabled");
endmodule : asp_serial_port_asserts

`default_nettype wire

// *** sim/tb_top.sv ***
/*
 * tb_top: register-level tests of the serial port against a remote transceiver.
 * Assumes a 40 MHz core clock; tests set a 32-cycle bit time.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import asp_pkg::*;

    localparam int         BIT = 32;
    localparam logic [7:0] TICKS [8] = '{8'h60, 8'h18, 8'h08, 8'h02, 8'h03, 8'h08, 8'h00, 8'h00};
    localparam logic [7:0] TXB [2] = '{8'hA5, 8'h3C};
    // a zero control entry leaves the flags alone to force an overrun
    localparam logic [7:0] RX_CTL [6] = '{8'h10, 8'h00, 8'hB0, 8'hB0, 8'h90, 8'h30};
    localparam logic [7:0] RX_D [6] = '{8'h5A, 8'h77, 8'h33, 8'hC3, 8'h96, 8'h11};
    localparam logic       RX_X [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    localparam logic [7:0] RX_ST [6] = '{8'h17, 8'h17, 8'hB2, 8'hB7, 8'h93, 8'h32};
    localparam logic [7:0] RX_BUF [6] = '{8'h5A, 8'h5A, 8'h5A, 8'hC3, 8'h96, 8'h96};

    logic       clk;
    logic       rst_n;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       rxd;
    logic       txd;
    logic       osc;
    logic       pin;
    logic       irq;
    logic [8:0] frame;
    int         cnt;
    int         error_cnt;
    int         checked;
    logic [7:0] v;
    logic [7:0] v0;

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        osc = 1'b0;
        forever #50 osc = ~osc;
    end
    initial begin
        pin = 1'b0;
        forever #150 pin = ~pin;
    end

    asp_serial_port i_asp_serial_port (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rxd(rxd), .o_txd(txd),
        .i_ext_osc(osc), .i_timer_ext_in(pin), .o_irq(irq));

    asp_remote_uart #(.BIT(BIT)) i_asp_remote_uart (
        .i_core_clk(clk), .i_line(txd), .o_line(rxd), .o_frame(frame), .o_cnt(cnt));

    ////////////////////////////////////////////////////////////////////////
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic rdc(input string n, input logic [2:0] a, input logic [7:0] e);
        rd_reg(a, v);
        chk(n, {1'b0, v}, {1'b0, e});
    endtask : rdc

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    task automatic wait_cnt(input int n);
        for (int i = 0; i < 40 * BIT; i++) begin
            if (cnt >= n) return;
            @(posedge clk);
        end
        error_cnt++;
        $display("mismatch frame count expected %0d seen %0d", n, cnt);
        complete_run();
    endtask : wait_cnt

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        error_cnt = 0;
        checked = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 8; a++) rdc("reset", a[2:0], 8'h00);
        $display("test reset done");

        wr_reg(ADR_RELOAD, 8'h5A);
        rdc("reload", ADR_RELOAD, 8'h5A);
        wr_reg(ADR_RELOAD, 8'h00);
        for (int s = 0; s < 8; s++) begin
            wr_reg(ADR_TCFG, {4'h0, s[2:0], 1'b1});
            rd_reg(ADR_TLOW, v0);
            repeat (94) @(posedge clk);
            rd_reg(ADR_TLOW, v);
            chk("ticks", {1'b0, v - v0}, {1'b0, TICKS[s]});
        end
        $display("test clock done");

        wr_reg(ADR_RELOAD, 8'hF0);
        wr_reg(ADR_TCFG, 8'h11);
        for (int m = 0; m < 2; m++) begin
            wr_reg(ADR_CTRL, {m[0], 7'h00});
            wr_reg(ADR_DATA, TXB[m]);
            wait_cnt(m + 1);
            chk("tx frame", frame, {~m[0], TXB[m]});
            rdc("ti edge", ADR_CTRL, {m[0], 5'h00, ~m[0], 1'b0});
            cyc(2 * BIT);
            chk("irq", {8'h00, irq}, 9'h001);
            rdc("no tx read", ADR_DATA, 8'h00);
            wr_reg(ADR_CTRL, {m[0], 7'h00});
            cyc(3);
            chk("irq off", {8'h00, irq}, 9'h000);
        end
        $display("test tx done");

        for (int k = 0; k < 6; k++) begin
            if (RX_CTL[k] != 8'h00) wr_reg(ADR_CTRL, RX_CTL[k]);
            fork
                i_asp_remote_uart.send(RX_D[k], RX_X[k]);
                wr_reg(ADR_DATA, ~RX_D[k]);
            join
            wait_cnt(3 + k);
            cyc(BIT);
            chk("duplex", frame, {~RX_CTL[k][7], ~RX_D[k]});
            rdc("rx flags", ADR_CTRL, RX_ST[k]);
            rdc("rx buf", ADR_DATA, RX_BUF[k]);
        end
        $display("test rx done");

        chk("irq rx", {8'h00, irq}, 9'h001);
        wr_reg(ADR_TCFG, 8'h01);
        cyc(2);
        chk("irq masked", {8'h00, irq}, 9'h000);

        wr_reg(ADR_CTRL, 8'h10);
        i_asp_remote_uart.pulse();
        rdc("glitch", ADR_CTRL, 8'h10);
        $display("test glitch done");
        complete_run();
    end
endmodule : tb_top

bind asp_serial_port asp_serial_port_asserts i_asp_serial_port_asserts (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(i_rxd), .o_txd(o_txd),
    .i_ext_osc(i_ext_osc), .i_timer_ext_in(i_timer_ext_in), .o_irq(o_irq));

`default_nettype wire
